/* File: common/bmfifo_pkg.sv */
`default_nettype none
package bmfifo_pkg;
    // widths
    localparam int DATA_W     = 36;
    localparam int LANE_W     = 9;
    localparam int ADDR_W     = 10;
    localparam int OFS_W      = 10;
    localparam int CNT_W      = ADDR_W + 1;
    // default offset table, indexed by {load, sel_hi, sel_lo}
    localparam logic [OFS_W-1:0] OFS_DEF [8] = '{
        10'h3FF, 10'h007, 10'h00F, 10'h01F,
        10'h03F, 10'h07F, 10'h0FF, 10'h1FF};
    // parity lane positions
    localparam int PAR_B0 = 8;
    localparam int PAR_B1 = 17;
    localparam int PAR_B2 = 26;
    localparam int PAR_B3 = 35;
    localparam int NPAR_HI_LO = 32;

    typedef enum logic [1:0] {
        BMF_W36_R36, BMF_W36_R18, BMF_W36_R9, BMF_W_NARROW
    } bmfifo_width_t;

    // captured configuration
    typedef struct packed {
        logic          fall_through_mode;
        logic          little_endian;
        logic          width_match;
        logic          input_width;
        logic          output_width;
        logic          serial_load;
        logic          interspersed;
        logic [2:0]    ofs_sel;
    } bmfifo_cfg_t;

    localparam bmfifo_cfg_t CFG_RST = '0;
endpackage
`default_nettype wire

/* File: hw/bmfifo_core.sv */
// Summary of operation
// RULE_01: byte order pin caught during master reset; low big, high little.
// RULE_02: write and read widths decided jointly from three width pins.
// RULE_03: width table: 36/36, 36/18, 36/9, 18/36, 9/36.
// RULE_04: write port is 36 bits; unused upper bits ignored when narrow.
// RULE_05: first shared flag: empty in standard, output ready in fall-through.
// RULE_06: second shared flag: full in standard, input ready in fall-through.
// RULE_07: flag selects plus load choose one of eight default offsets.
// RULE_08: load picks serial or parallel; after reset it gates offset access.
// RULE_09: mode pin picks timing mode at reset, later serial offset input.
// RULE_10: reset values of shared flags follow the chosen mode.
// RULE_11: half-full output tells whether count is above half capacity.
// RULE_12: half-full is active low, high after reset.
// RULE_13: parity placement affects only parallel offset loads.
// RULE_14: parity bits 8,17,26,35 skipped or bits 32-35 ignored.
// RULE_15: master reset zeroes pointers and the output data register.
// RULE_16: all options are captured while master reset is active; the code latches them on the third clock after release.
// RULE_17: host applies master reset before any write.
// RULE_18: configuration held fixed until the next master reset.
// RULE_19: read data outputs disabled under the output enable input.
// RULE_20: almost-empty low below the empty offset, high at or above.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module bmfifo_core
    import bmfifo_pkg::*;
#(
    parameter int DEPTH = 1 << bmfifo_pkg::ADDR_W
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     byte_order_select,
    input  wire logic                     width_match_select,
    input  wire logic                     input_width_select,
    input  wire logic                     output_width_select,
    input  wire logic                     offset_default_sel_lo,
    input  wire logic                     offset_default_sel_hi,
    input  wire logic                     offset_load_enable,
    input  wire logic                     mode_or_serial_in,
    input  wire logic                     parity_placement_select,
    input  wire logic                     serial_enable,
    input  wire logic                     write_enable,
    input  wire logic [bmfifo_pkg::DATA_W-1:0] write_data_in,
    input  wire logic                     read_enable,
    input  wire logic                     output_enable,
    output logic [bmfifo_pkg::DATA_W-1:0] read_data_out,
    output logic                          read_data_oe,
    output logic                          empty_or_output_ready,
    output logic                          full_or_input_ready,
    output logic                          half_full_flag,
    output logic                          almost_empty_flag,
    output logic                          width_36_write,
    output logic                          width_36_read
);
    import bmfifo_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [7:0] pin_s1_q;
    logic [7:0] pin_s2_q;
    logic [7:0] pin_raw;
    assign pin_raw = {byte_order_select, width_match_select,
                      input_width_select, output_width_select,
                      offset_default_sel_lo, offset_default_sel_hi,
                      mode_or_serial_in, parity_placement_select};
    // no reset: the pins must be seen while master reset is still low
    always_ff @(posedge clk) begin
        pin_s1_q <= pin_raw;
        pin_s2_q <= pin_s1_q;
    end
    logic [1:0] ld_s_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_s_q <= 2'h0;
        end else begin
            ld_s_q <= {ld_s_q[0], offset_load_enable};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration capture: the third clock after release latches pins
    logic        cfg_done_q;
    logic [1:0]  settle_q;
    bmfifo_cfg_t cfg_q;
    bmfifo_cfg_t cfg_d;
    logic        capture;
    assign capture = !cfg_done_q && (settle_q == 2'h2);
    assign cfg_d = '{fall_through_mode: pin_s2_q[1],   // RULE_09
                     little_endian:     pin_s2_q[7],   // RULE_01
                     width_match:       pin_s2_q[6],   // RULE_02
                     input_width:       pin_s2_q[5],
                     output_width:      pin_s2_q[4],
                     serial_load:       ld_s_q[1],     // RULE_08
                     interspersed:      pin_s2_q[0],   // RULE_13
                     ofs_sel:           {ld_s_q[1], pin_s2_q[2],
                                         pin_s2_q[3]}}; // RULE_07
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q      <= CFG_RST;
            cfg_done_q <= 1'b0;
            settle_q   <= 2'h0;
        end else if (capture) begin
            cfg_q      <= cfg_d;   // RULE_16
            cfg_done_q <= 1'b1;    // RULE_18
        end else if (!cfg_done_q) begin
            settle_q   <= settle_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // width decode
    bmfifo_width_t wmode;
    assign wmode = !cfg_q.width_match ? BMF_W36_R36 :              // RULE_03
                   cfg_q.input_width  ? BMF_W_NARROW :
                   cfg_q.output_width ? BMF_W36_R9 : BMF_W36_R18;
    assign width_36_write = (wmode != BMF_W_NARROW);               // RULE_02
    assign width_36_read  = (wmode == BMF_W36_R36) ||
                            (wmode == BMF_W_NARROW);
    // lanes per 36-bit word on the narrow side: 1, 2 or 4
    logic [2:0] lanes;
    assign lanes = (wmode == BMF_W36_R36) ? 3'h1 :
                   (wmode == BMF_W36_R18) ? 3'h2 :
                   (wmode == BMF_W36_R9)  ? 3'h4 :
                   (cfg_q.output_width ? 3'h4 : 3'h2);
    logic [2:0] lane_w;
    assign lane_w = (lanes == 3'h4) ? 3'h1 : ((lanes == 3'h2) ? 3'h2 : 3'h4);

    ////////////////////////////////////////////////////////////////////////
    // lane position, big-endian sends high lane first
    function automatic logic [1:0] bmf_pos(input logic [1:0] idx,
                                           input logic [2:0] n,
                                           input logic       le);
        logic [1:0] r;
        r = le ? idx : 2'(n - 3'h1 - {1'b0, idx});
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // memory and pointers
    logic [DATA_W-1:0] mem [DEPTH];
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // wrap at array end
    logic [AW-1:0]     wptr_q;
    logic [AW-1:0]     rptr_q;
    logic [CNT_W-1:0]  count_q;
    logic [1:0]        wlane_q;
    logic [1:0]        rlane_q;
    logic [DATA_W-1:0] wasm_q;
    logic [DATA_W-1:0] rdata_q;
    logic              ft_valid_q;
    logic              run;
    assign run = cfg_done_q && !ld_s_q[1];
    logic full;
    logic empty;
    assign full  = (count_q == CNT_W'(DEPTH));
    assign empty = (count_q == '0);

    // narrow write assembly; upper input bits beyond the lane are dropped
    logic [DATA_W-1:0] win_masked;
    logic [DATA_W-1:0] wasm_d;
    logic [1:0]        wpos;
    assign win_masked = (wmode != BMF_W_NARROW) ? write_data_in :
        (cfg_q.output_width ? {27'h0, write_data_in[8:0]} :     // RULE_04
                              {18'h0, write_data_in[17:0]});
    assign wpos = bmf_pos(wlane_q, lanes, cfg_q.little_endian);
    assign wasm_d = (wmode != BMF_W_NARROW) ? win_masked :
        (wasm_q | (win_masked << (wpos * lane_w * LANE_W)));
    logic wlast;
    assign wlast = (wmode != BMF_W_NARROW) ||
                   (wlane_q == 2'(lanes - 3'h1));
    logic wr_word;
    assign wr_word = run && write_enable && !full && wlast;
    logic wr_lane;
    assign wr_lane = run && write_enable && !full;

    // narrow read lane selection
    logic        narrow_rd;
    assign narrow_rd = (wmode == BMF_W36_R18) || (wmode == BMF_W36_R9);
    logic [1:0]  rpos;
    assign rpos = bmf_pos(rlane_q, lanes, cfg_q.little_endian);   // RULE_01
    logic [DATA_W-1:0] rword;
    assign rword = mem[rptr_q];
    logic [DATA_W-1:0] rsel;
    assign rsel = narrow_rd ? (rword >> (rpos * lane_w * LANE_W)) &
                  ((DATA_W'(1) << (lane_w * LANE_W)) - DATA_W'(1)) : rword;
    logic rlast;
    assign rlast = !narrow_rd || (rlane_q == 2'(lanes - 3'h1));
    logic rd_take;
    // fall-through presents the head without a request
    assign rd_take = run && !empty &&
        (cfg_q.fall_through_mode ? (!ft_valid_q || read_enable)
                                 : read_enable);
    logic rd_word;
    assign rd_word = rd_take && rlast;

    always_ff @(posedge clk) begin
        if (wr_word) begin
            mem[wptr_q] <= wasm_d;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_q  <= '0;          // RULE_15
            rptr_q  <= '0;
            wlane_q <= 2'h0;
            rlane_q <= 2'h0;
            wasm_q  <= '0;
        end else begin
            if (wr_lane) begin
                wlane_q <= wlast ? 2'h0 : wlane_q + 2'h1;
                wasm_q  <= wlast ? '0 : wasm_d;
            end
            if (wr_word) begin
                wptr_q <= wptr_q + AW'(1);
            end
            if (rd_take) begin
                rlane_q <= rlast ? 2'h0 : rlane_q + 2'h1;
            end
            if (rd_word) begin
                rptr_q <= rptr_q + AW'(1);
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (wr_word && !rd_word) begin
            count_q <= count_q + CNT_W'(1);
        end else if (rd_word && !wr_word) begin
            count_q <= count_q - CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // offset registers: serial shift or parallel load while load is high
    logic [OFS_W-1:0] empty_ofs_q;
    logic [OFS_W-1:0] par_ofs;
    assign par_ofs = cfg_q.interspersed ?                         // RULE_14
        OFS_W'({write_data_in[PAR_B1-1:PAR_B0+1],
                write_data_in[PAR_B0-1:0]}) :
        OFS_W'(write_data_in[NPAR_HI_LO-1:0]);
    logic ofs_access;
    assign ofs_access = cfg_done_q && ld_s_q[1];                  // RULE_08
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            empty_ofs_q <= OFS_DEF[0];  // largest offset keeps almost-empty low
        end else if (capture) begin
            empty_ofs_q <= OFS_DEF[cfg_d.ofs_sel];                // RULE_07
        end else if (ofs_access && cfg_q.serial_load && serial_enable) begin
            empty_ofs_q <= {empty_ofs_q[OFS_W-2:0], pin_s2_q[1]}; // RULE_09
        end else if (ofs_access && !cfg_q.serial_load && write_enable) begin
            empty_ofs_q <= par_ofs;                               // RULE_13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output register and ready tracking
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q    <= '0;       // RULE_15
            ft_valid_q <= 1'b0;
        end else if (ofs_access && read_enable) begin
            rdata_q <= DATA_W'(empty_ofs_q);
        end else if (rd_take) begin
            rdata_q    <= rsel;
            ft_valid_q <= 1'b1;
        end else if (read_enable && cfg_q.fall_through_mode) begin
            ft_valid_q <= 1'b0;
        end
    end
    assign read_data_out = rdata_q;
    assign read_data_oe  = output_enable;                         // RULE_19

    ////////////////////////////////////////////////////////////////////////
    // flags; before capture the synchronised mode pin picks their meaning
    logic mode_ft;
    assign mode_ft = cfg_done_q ? cfg_q.fall_through_mode         // RULE_10
                                : pin_s2_q[1];
    assign empty_or_output_ready = mode_ft ? !ft_valid_q : !empty; // RULE_05
    assign full_or_input_ready   = mode_ft ? full : !full;         // RULE_06
    assign half_full_flag = !(count_q > CNT_W'(DEPTH / 2));       // RULE_11
    assign almost_empty_flag =                                    // RULE_20
        (count_q >= CNT_W'(empty_ofs_q));

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_half_low;
        @(posedge clk) disable iff (!rst_n)
        (count_q > CNT_W'(DEPTH / 2)) |-> !half_full_flag;
    endproperty
    a_half_low: assert property (p_half_low) // RULE_12
        else $error("half-full not low above half");
    property p_cfg_hold;
        @(posedge clk) disable iff (!rst_n)
        cfg_done_q |=> $stable(cfg_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) // RULE_18
        else $error("configuration changed after capture");
    property p_pae;
        @(posedge clk) disable iff (!rst_n)
        (count_q < CNT_W'(empty_ofs_q)) |-> !almost_empty_flag;
    endproperty
    a_pae: assert property (p_pae) // RULE_20
        else $error("almost-empty high below offset");
    property p_empty_std;
        @(posedge clk) disable iff (!rst_n)
        (!mode_ft && empty) |-> !empty_or_output_ready;
    endproperty
    a_empty_std: assert property (p_empty_std) // RULE_05
        else $error("empty flag not low when empty");
    property p_full_std;
        @(posedge clk) disable iff (!rst_n)
        (!mode_ft && full) |-> !full_or_input_ready;
    endproperty
    a_full_std: assert property (p_full_std) // RULE_06
        else $error("full flag not low when full");
    property p_ptr_move;
        @(posedge clk) disable iff (!rst_n)
        wr_word |=> (wptr_q == $past(wptr_q) + AW'(1));
    endproperty
    a_ptr_move: assert property (p_ptr_move) // RULE_15
        else $error("write pointer did not advance");
    property p_oe;
        @(posedge clk) disable iff (!rst_n)
        read_data_oe == output_enable;
    endproperty
    a_oe: assert property (p_oe) // RULE_19
        else $error("output enable mismatch");
    property p_capture;
        @(posedge clk) disable iff (!rst_n)
        capture |=> (cfg_q == $past(cfg_d)) && cfg_done_q;
    endproperty
    a_capture: assert property (p_capture) // RULE_16
        else $error("configuration not captured");
    property p_ft_start;
        @(posedge clk)
        (!cfg_done_q && mode_ft) |-> empty_or_output_ready &&
                                     !full_or_input_ready;
    endproperty
    a_ft_start: assert property (p_ft_start) // RULE_10
        else $error("fall-through flags wrong before capture");
    property p_ofs_shift;
        @(posedge clk) disable iff (!rst_n)
        (ofs_access && cfg_q.serial_load && serial_enable) |=>
            (empty_ofs_q == {$past(empty_ofs_q[OFS_W-2:0]),
                             $past(pin_s2_q[1])});
    endproperty
    a_ofs_shift: assert property (p_ofs_shift) // RULE_09
        else $error("serial offset bit not shifted in");
endmodule
`default_nettype wire

/* File: tb/bmfifo_host.sv */
`timescale 1ns/1ns
`default_nettype none
module bmfifo_host
    import bmfifo_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    output var  logic                          write_enable,
    output var  logic [bmfifo_pkg::DATA_W-1:0] write_data_in,
    output var  logic                          read_enable
);
    int unsigned since_rst;

    initial begin
        write_enable = 1'b0;
        read_enable = 1'b0;
        write_data_in = '0;
    end

    // edges seen since master reset was released
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_rst <= 0;
        end else if (since_rst < 8) begin
            since_rst <= since_rst + 1;
        end
    end

    // back-to-back words base, base+step, ...; idle bus shows inverse
    task automatic write_words(input logic [DATA_W-1:0] base, input int n,
                               input logic [DATA_W-1:0] step);
        logic [DATA_W-1:0] w;
        w = base;
        while (since_rst < 4) begin
            @(posedge clk);
            #1;
        end
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            write_enable <= 1'b1;
            write_data_in <= w;
            w = w + step;
        end
        @(posedge clk);
        write_enable <= 1'b0;
        write_data_in <= ~(w - step);
        #1;
    endtask

    // one read strobe; data settled on return
    task automatic read_one();
        @(posedge clk);
        read_enable <= 1'b1;
        @(posedge clk);
        read_enable <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import bmfifo_pkg::*;
    localparam int DEPTH = 16;
    localparam logic [DATA_W-1:0] BASE = 36'hF0F0F0F00;
    localparam logic [DATA_W-1:0] STEP = 36'h101010101;
    logic              clk, rst_n, bo, wm, iw, ow, slo, shi, ld, mode, ip;
    logic              sen, oe, we, re, rd_oe, ef, ff, hf, ae, w36, r36;
    logic [DATA_W-1:0] wd, rd, x, y;
    int                err_count, checks_done, k;
    int                n_tab [7] = '{6, 1, 1, 1, 6, 1, 1};
    logic [3:0]        f_tab [7] = '{4'hE, 4'hF, 4'hF, 4'hD, 4'hD, 4'h9, 4'h9};
    logic [2:0]        w_tab [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [1:0]        d_tab [5] = '{2'h3, 2'h2, 2'h2, 2'h1, 2'h1};

    bmfifo_core #(.DEPTH(DEPTH)) i_dut (
        .clk(clk), .rst_n(rst_n), .byte_order_select(bo),
        .width_match_select(wm), .input_width_select(iw),
        .output_width_select(ow), .offset_default_sel_lo(slo),
        .offset_default_sel_hi(shi), .offset_load_enable(ld),
        .mode_or_serial_in(mode), .parity_placement_select(ip),
        .serial_enable(sen), .write_enable(we), .write_data_in(wd),
        .read_enable(re), .output_enable(oe), .read_data_out(rd),
        .read_data_oe(rd_oe), .empty_or_output_ready(ef),
        .full_or_input_ready(ff), .half_full_flag(hf),
        .almost_empty_flag(ae), .width_36_write(w36), .width_36_read(r36));

    bmfifo_host i_host (
        .clk(clk), .rst_n(rst_n), .write_enable(we),
        .write_data_in(wd), .read_enable(re));

    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        err_count++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [DATA_W-1:0] word_k(input int i);
        return BASE + STEP * DATA_W'(i);
    endfunction

    task automatic check(input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // pins {bo,wm,iw,ow,slo,shi,ld,mode,ip}, held through capture
    task automatic reset_dut(input logic [8:0] c);
        @(posedge clk);
        rst_n <= 1'b0;
        {bo, wm, iw, ow, slo, shi, ld, mode, ip} <= c;
        repeat (4) @(posedge clk);
        #1;
        check({32'h0, ef, ff, hf, ae},
              {32'h0, c[1], ~c[1], 2'b10});
        check(rd, '0);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic chk_flags(input logic [3:0] e);
        repeat (2) @(posedge clk);
        #1;
        check({32'h0, ef, ff, hf, ae}, {32'h0, e});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {bo, wm, iw, ow, slo, shi, ld, mode, ip} = '0;
        rst_n = 1'b0;
        sen = 1'b0;
        oe = 1'b0;
        err_count = 0;
        checks_done = 0;
        reset_dut(9'b000010000);
        @(posedge clk);
        wm <= 1'b1;
        iw <= 1'b1;
        oe <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check({34'h0, w36, r36}, 36'h3);
        check({35'h0, rd_oe}, 36'h1);
        @(posedge clk);
        oe <= 1'b0;
        @(posedge clk);
        #1;
        check({35'h0, rd_oe}, 36'h0);
        // fill past full, flags at each boundary, offset 7
        k = 0;
        for (int i = 0; i < 7; i++) begin
            i_host.write_words(word_k(k), n_tab[i], STEP);
            k += n_tab[i];
            chk_flags(f_tab[i]);
        end
        for (int i = 0; i < DEPTH; i++) begin
            i_host.read_one();
            check(rd, word_k(i));
        end
        chk_flags(4'h6);
        i_host.read_one();
        check(rd, word_k(DEPTH - 1));
        // width decode
        for (int i = 0; i < 5; i++) begin
            reset_dut({1'b0, w_tab[i], 5'b10000});
            check({34'h0, w36, r36}, {34'h0, d_tab[i]});
        end
        // lane order both ways, junk above narrow lanes
        x = 36'h123456789;
        for (int b = 0; b < 2; b++) begin
            reset_dut({b[0], 3'b101, 5'b10000});
            i_host.write_words(x, 1, '0);
            for (int i = 0; i < 4; i++) begin
                i_host.read_one();
                k = 9 * (b ? i : 3 - i);
                check({27'h0, rd[8:0]}, {27'h0, x[k +: 9]});
            end
            reset_dut({b[0], 3'b100, 5'b10000});
            i_host.write_words(x, 1, '0);
            for (int i = 0; i < 2; i++) begin
                i_host.read_one();
                k = 18 * (b ? i : 1 - i);
                check({18'h0, rd[17:0]}, {18'h0, x[k +: 18]});
            end
            reset_dut({b[0], 3'b111, 5'b10000});
            i_host.write_words(36'hABCDE0011, 4, 36'h11);
            i_host.read_one();
            y = b ? {9'h044, 9'h033, 9'h022, 9'h011}
                  : {9'h011, 9'h022, 9'h033, 9'h044};
            check(rd, y);
            reset_dut({b[0], 3'b110, 5'b10000});
            i_host.write_words(36'hABCD01234, 2, 36'h1);
            i_host.read_one();
            y = b ? {18'h01235, 18'h01234} : {18'h01234, 18'h01235};
            check(rd, y);
        end
        // fall-through mode
        reset_dut(9'b000010010);
        i_host.write_words(x, 1, '0);
        for (int i = 0; i < 10 && ef !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        check({34'h0, ef, ff}, 36'h0);
        check(rd, x);
        // parallel offset 3 with parity in bit 8
        reset_dut(9'b000010001);
        @(posedge clk);
        ld <= 1'b1;
        repeat (4) @(posedge clk);
        i_host.write_words(36'h000000103, 1, '0);
        i_host.read_one();
        check(rd, 36'h3);
        @(posedge clk);
        ld <= 1'b0;
        repeat (4) @(posedge clk);
        i_host.write_words(BASE, 2, STEP);
        chk_flags(4'hE);
        i_host.write_words(BASE, 1, STEP);
        chk_flags(4'hF);
        // serial offset: default read back, then ten zeros and two ones
        reset_dut(9'b000000100);
        i_host.read_one();
        check(rd, DATA_W'(OFS_DEF[4]));
        @(posedge clk);
        sen <= 1'b1;
        repeat (8) @(posedge clk);
        mode <= 1'b1;
        repeat (4) @(posedge clk);
        sen <= 1'b0;
        i_host.read_one();
        check(rd, 36'h3);
        @(posedge clk);
        ld <= 1'b0;
        repeat (4) @(posedge clk);
        i_host.write_words(BASE, 2, STEP);
        chk_flags(4'hE);
        i_host.write_words(BASE, 1, STEP);
        chk_flags(4'hF);
        stop_test();
    end
endmodule
`default_nettype wire
